// ==== inc/lssq_pkg.sv ====
// package of constants for the load switch sequencer
// assumes a 40 MHz core clock and an i2c target front end
package lssq_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CHIPID = 8'h00;
    localparam logic [7:0] REG_VERID = 8'h01;
    localparam logic [7:0] REG_EN = 8'h02;
    localparam logic [7:0] REG_DIS = 8'h03;
    localparam logic [7:0] REG_TR0 = 8'h04;
    localparam logic [7:0] REG_SLOT_ASSIGN_CH1_CH2 = 8'h05;
    localparam logic [7:0] REG_SLOT_ASSIGN_CH3_CH4 = 8'h06;
    localparam logic [7:0] REG_SLOT_ASSIGN_CH5_CH6 = 8'h07;
    localparam logic [7:0] REG_SEQCTL = 8'h08;
    localparam logic [7:0] REG_TR1 = 8'h09;
    localparam logic [7:0] REG_RCB = 8'h0A;
    localparam logic [7:0] REG_STA = 8'h0B;
    localparam logic [7:0] REG_SOFTRST = 8'h69;
    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CHIPID = 8'h30;
    localparam logic [7:0] RST_VERID = 8'h00;
    localparam logic [5:0] RST_DIS = 6'h3F;
    localparam logic [7:0] SOFTRST_KEY = 8'hB0;
    localparam logic [1:0] CMD_UP = 2'h1;
    localparam logic [1:0] CMD_DOWN = 2'h2;
    localparam logic [2:0] SLOT_IDLE = 3'h0;
    localparam logic [2:0] SLOT_LAST = 3'h7;
    localparam logic [6:0] ADDR_BASE = 7'h18;
    // ------------------------------------------------------------
    // slot timing: base slot time in microseconds, scaled by speed field
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int SLOT_US = 250;
    localparam int SLOT_CYC = SLOT_US * CLK_MHZ;
endpackage

// ==== inc/lssq_if.sv ====
// register write/read carrier between i2c front end and register file
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface lssq_if;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport target(output wr, output addr, output wdata, input rdata);
    modport regs(input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== rtl/lssq_i2c.sv ====
// i2c target: address match, register pointer, auto increment
// assumes scl and sda already synchronised to core_clk_i
`timescale 1ns/1ps
`default_nettype none
module lssq_i2c (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // synchronised bus levels
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic addr_sel_i,
    // open drain sda, oe low drives low
    output logic sda_oe_n_o,
    // register side
    lssq_if.target rb
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        LSSQ_IDLE = 5'b00001,
        LSSQ_RX = 5'b00010,
        LSSQ_ACK = 5'b00100,
        LSSQ_TX = 5'b01000,
        LSSQ_MACK = 5'b10000
    } lssq_st_t;

    lssq_st_t st_reg;
    logic scl_d_reg, sda_d_reg;
    logic [7:0] sh_reg;
    logic [3:0] bit_reg;
    logic [1:0] phase_reg; // 0 address, 1 pointer, 2 data
    logic rd_reg;
    logic [7:0] ptr_reg;
    logic drive_low_reg;
    logic wr_reg;
    logic [7:0] wdata_reg;

    wire scl_rise = scl_i & ~scl_d_reg;
    wire scl_fall = ~scl_i & scl_d_reg;
    wire start_c = scl_i & scl_d_reg & sda_d_reg & ~sda_i;
    wire stop_c = scl_i & scl_d_reg & ~sda_d_reg & sda_i;
    wire [6:0] my_addr = {lssq_pkg::ADDR_BASE[6:1], addr_sel_i};

    assign sda_oe_n_o = ~drive_low_reg;
    assign rb.wr = wr_reg;
    assign rb.addr = ptr_reg;
    assign rb.wdata = wdata_reg;

    // ------------------------------------------------------------
    // bus engine
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        scl_d_reg <= scl_i;
        sda_d_reg <= sda_i;
        wr_reg <= 1'b0;
        if (!rst_n_i) begin
            st_reg <= LSSQ_IDLE;
            sh_reg <= 8'h00;
            bit_reg <= 4'h0;
            phase_reg <= 2'h0;
            rd_reg <= 1'b0;
            ptr_reg <= 8'h00;
            drive_low_reg <= 1'b0;
            wdata_reg <= 8'h00;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else if (start_c) begin
            st_reg <= LSSQ_RX;
            phase_reg <= 2'h0;
            bit_reg <= 4'h0;
            drive_low_reg <= 1'b0;
        end else if (stop_c) begin
            st_reg <= LSSQ_IDLE;
            drive_low_reg <= 1'b0;
        end else begin
            unique case (st_reg)
                LSSQ_IDLE: begin
                    drive_low_reg <= 1'b0;
                end
                LSSQ_RX: begin
                    if (scl_rise) begin
                        sh_reg <= {sh_reg[6:0], sda_i};
                        bit_reg <= bit_reg + 4'h1;
                    end else if (scl_fall && bit_reg == 4'h8) begin
                        bit_reg <= 4'h0;
                        if (phase_reg == 2'h0) begin
                            if (sh_reg[7:1] == my_addr) begin
                                rd_reg <= sh_reg[0];
                                drive_low_reg <= 1'b1;
                                st_reg <= LSSQ_ACK;
                            end else begin
                                st_reg <= LSSQ_IDLE;
                            end
                        end else begin
                            drive_low_reg <= 1'b1;
                            st_reg <= LSSQ_ACK;
                        end
                    end
                end
                LSSQ_ACK: begin
                    if (scl_fall) begin
                        drive_low_reg <= 1'b0;
                        if (phase_reg == 2'h1) begin
                            ptr_reg <= sh_reg;
                        end else if (phase_reg == 2'h2) begin
                            wdata_reg <= sh_reg;
                            wr_reg <= 1'b1;
                        end
                        if (phase_reg == 2'h0 && rd_reg) begin
                            sh_reg <= rb.rdata;
                            drive_low_reg <= ~rb.rdata[7];
                            bit_reg <= 4'h1;
                            st_reg <= LSSQ_TX;
                        end else begin
                            st_reg <= LSSQ_RX;
                            phase_reg <= (phase_reg == 2'h0) ? 2'h1 : 2'h2;
                        end
                    end
                end
                LSSQ_TX: begin
                    if (scl_fall) begin
                        if (bit_reg == 4'h8) begin
                            drive_low_reg <= 1'b0;
                            st_reg <= LSSQ_MACK;
                            ptr_reg <= ptr_reg + 8'h01;
                        end else begin
                            drive_low_reg <= ~sh_reg[3'h7 - bit_reg[2:0]];
                            bit_reg <= bit_reg + 4'h1;
                        end
                    end
                end
                LSSQ_MACK: begin
                    if (scl_rise) begin
                        st_reg <= sda_i ? LSSQ_IDLE : LSSQ_ACK;
                    end
                end
                default: st_reg <= LSSQ_IDLE;
            endcase
            if (wr_reg) begin
                ptr_reg <= ptr_reg + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ==== rtl/lssq_top.sv ====
// load switch sequencer top: registers, slot sequencer, switch controls
// assumes raw scl/sda pins, enable pin drives synchronous reset path
// Notes on behaviour
// - slot code zero means the channel follows its enable bit directly.
// - seven slots; each channel holds a three-bit slot code, nonzero means sequenced.
// - command 01 runs power-up, counter climbs 001 to 111, then wraps to 000.
// - command 10 runs power-down, counter falls 111 to 000.
// - channels in the current slot turn on going up, off going down.
// - counter at 000 means no sequence running.
// - active flag high from first slot start to last slot end, going up (1 to 7) or down (7 to 1).
// - enable pin low shuts down and resets all registers.
// - enable pin low makes the bus ignored entirely.
// - an off channel with discharge bit set has its discharge path on.
// - off channels always block reverse current; on channels when bit set.
// - sda changes only while scl low, except start and stop.
// - bytes go msb first, each followed by one acknowledge bit.
// - each received write byte is acknowledged by pulling sda low.
// - target address 0011000 with select low, 0011001 with select high.
// - pointer byte follows address, then data bytes auto increment.
// - writing B0 to register 69 resets every register.
`timescale 1ns/1ps
`default_nettype none
module lssq_top #(
    parameter int NCH = 6,
    parameter int SLOT_CYCLES = lssq_pkg::SLOT_CYC,
    parameter logic [1:0] CHIP_REV = 2'h0 // arbitrary value
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // device pins
    input wire logic enable_pin_i,
    input wire logic addr_sel_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // switch controls
    output logic [5:0] switch_on_o,
    output logic [5:0] discharge_on_o,
    output logic [5:0] rcb_on_o,
    output logic seq_active_o
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] s1_reg, s2_reg;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            s1_reg <= 4'hF;
            s2_reg <= 4'hF;
        end else begin
            s1_reg <= {enable_pin_i, addr_sel_i, scl_i, sda_i};
            s2_reg <= s1_reg;
        end
    end
    wire en_s = s2_reg[3];
    wire run_n = rst_n_i & en_s;

    // ------------------------------------------------------------
    // i2c front end, held in reset while enable pin low
    // ------------------------------------------------------------
    lssq_if rbus ();
    logic oe_n_int;
    lssq_i2c u_i2c (
        .core_clk_i(core_clk_i),
        .rst_n_i(run_n),
        .scl_i(s2_reg[1]),
        .sda_i(s2_reg[0]),
        .addr_sel_i(s2_reg[2]),
        .sda_oe_n_o(oe_n_int),
        .rb(rbus)
    );
    assign sda_o = 1'b0;
    assign sda_oe_n_o = oe_n_int | ~en_s;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [5:0] en_reg, dis_reg, tr0_reg, tr1_reg, rcb_reg;
    logic [2:0] slot_reg [NCH];
    logic [1:0] speed_reg;
    logic [1:0] cmd_reg;
    logic [2:0] cnt_reg;
    logic seq_on_reg;
    logic [5:0] seq_out_reg;
    logic [31:0] tick_reg;
    logic dir_up_reg;

    wire soft_rst = rbus.wr && rbus.addr == lssq_pkg::REG_SOFTRST
        && rbus.wdata == lssq_pkg::SOFTRST_KEY;
    wire clr = !run_n || soft_rst;
    wire cmd_wr = rbus.wr && rbus.addr == lssq_pkg::REG_SEQCTL;

    always_ff @(posedge core_clk_i) begin
        if (clr) begin
            en_reg <= 6'h00;
            dis_reg <= lssq_pkg::RST_DIS;
            tr0_reg <= 6'h00;
            tr1_reg <= 6'h00;
            rcb_reg <= 6'h00;
            speed_reg <= 2'h0;
            for (int i = 0; i < NCH; i++) begin
                slot_reg[i] <= 3'h0;
            end
        end else if (rbus.wr) begin
            unique case (rbus.addr)
                lssq_pkg::REG_EN: en_reg <= rbus.wdata[5:0];
                lssq_pkg::REG_DIS: dis_reg <= rbus.wdata[5:0];
                lssq_pkg::REG_TR0: tr0_reg <= rbus.wdata[5:0];
                lssq_pkg::REG_TR1: tr1_reg <= rbus.wdata[5:0];
                lssq_pkg::REG_RCB: rcb_reg <= rbus.wdata[5:0];
                lssq_pkg::REG_SLOT_ASSIGN_CH1_CH2: begin
                    slot_reg[0] <= rbus.wdata[2:0];
                    slot_reg[1] <= rbus.wdata[5:3];
                end
                lssq_pkg::REG_SLOT_ASSIGN_CH3_CH4: begin
                    slot_reg[2] <= rbus.wdata[2:0];
                    slot_reg[3] <= rbus.wdata[5:3];
                end
                lssq_pkg::REG_SLOT_ASSIGN_CH5_CH6: begin
                    slot_reg[4] <= rbus.wdata[2:0];
                    slot_reg[5] <= rbus.wdata[5:3];
                end
                lssq_pkg::REG_SEQCTL: speed_reg <= rbus.wdata[7:6];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // slot sequencer
    // ------------------------------------------------------------
    function automatic logic [31:0] slot_len(input logic [1:0] spd);
        slot_len = SLOT_CYCLES << spd;
    endfunction

    always_ff @(posedge core_clk_i) begin
        if (clr) begin
            cmd_reg <= 2'h0;
            cnt_reg <= lssq_pkg::SLOT_IDLE;
            seq_on_reg <= 1'b0;
            tick_reg <= 32'h0;
            dir_up_reg <= 1'b1;
        end else if (cmd_wr && rbus.wdata[5:4] == lssq_pkg::CMD_UP && !seq_on_reg) begin
            cmd_reg <= lssq_pkg::CMD_UP;
            dir_up_reg <= 1'b1;
            cnt_reg <= 3'h1;
            seq_on_reg <= 1'b1;
            tick_reg <= 32'h0;
        end else if (cmd_wr && rbus.wdata[5:4] == lssq_pkg::CMD_DOWN && !seq_on_reg) begin
            cmd_reg <= lssq_pkg::CMD_DOWN;
            dir_up_reg <= 1'b0;
            cnt_reg <= lssq_pkg::SLOT_LAST;
            seq_on_reg <= 1'b1;
            tick_reg <= 32'h0;
        end else if (seq_on_reg) begin
            if (tick_reg >= slot_len(speed_reg) - 32'h1) begin
                tick_reg <= 32'h0;
                if (dir_up_reg) begin
                    cnt_reg <= cnt_reg + 3'h1; // wraps 7 -> 0 at end
                    seq_on_reg <= cnt_reg != lssq_pkg::SLOT_LAST;
                end else begin
                    cnt_reg <= cnt_reg - 3'h1;
                    seq_on_reg <= cnt_reg != 3'h1;
                end
                if ((dir_up_reg && cnt_reg == lssq_pkg::SLOT_LAST) || (!dir_up_reg && cnt_reg == 3'h1)) begin
                    cmd_reg <= 2'h0;
                end
            end else begin
                tick_reg <= tick_reg + 32'h1;
            end
        end
    end

    // sequenced channel state, applied at slot start
    always_ff @(posedge core_clk_i) begin
        if (clr) begin
            seq_out_reg <= 6'h00;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (seq_on_reg && cnt_reg != lssq_pkg::SLOT_IDLE && slot_reg[i] == cnt_reg) begin
                    seq_out_reg[i] <= dir_up_reg;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // switch control outputs
    // ------------------------------------------------------------
    logic [5:0] on_next;
    always_comb begin
        on_next = 6'h00;
        for (int i = 0; i < NCH; i++) begin
            on_next[i] = (slot_reg[i] == lssq_pkg::SLOT_IDLE) ? en_reg[i] : seq_out_reg[i];
        end
    end

    // while shut down every channel is off, so the default discharge selects apply
    always_ff @(posedge core_clk_i) begin
        if (clr) begin
            switch_on_o <= 6'h00;
            discharge_on_o <= lssq_pkg::RST_DIS;
            rcb_on_o <= 6'h3F;
            seq_active_o <= 1'b0;
        end else begin
            seq_active_o <= seq_on_reg;
            switch_on_o <= on_next;
            discharge_on_o <= ~on_next & dis_reg;
            rcb_on_o <= ~on_next | rcb_reg;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rbus.rdata = 8'h00;
        unique case (rbus.addr)
            lssq_pkg::REG_CHIPID: rbus.rdata = {lssq_pkg::RST_CHIPID[7:2], CHIP_REV};
            lssq_pkg::REG_VERID: rbus.rdata = lssq_pkg::RST_VERID;
            lssq_pkg::REG_EN: rbus.rdata = {2'h0, en_reg};
            lssq_pkg::REG_DIS: rbus.rdata = {2'h0, dis_reg};
            lssq_pkg::REG_TR0: rbus.rdata = {2'h0, tr0_reg};
            lssq_pkg::REG_SLOT_ASSIGN_CH1_CH2: rbus.rdata = {2'h0, slot_reg[1], slot_reg[0]};
            lssq_pkg::REG_SLOT_ASSIGN_CH3_CH4: rbus.rdata = {2'h0, slot_reg[3], slot_reg[2]};
            lssq_pkg::REG_SLOT_ASSIGN_CH5_CH6: rbus.rdata = {2'h0, slot_reg[5], slot_reg[4]};
            lssq_pkg::REG_SEQCTL: rbus.rdata = {speed_reg, cmd_reg, seq_on_reg, cnt_reg};
            lssq_pkg::REG_TR1: rbus.rdata = {2'h0, tr1_reg};
            lssq_pkg::REG_RCB: rbus.rdata = {2'h0, rcb_reg};
            lssq_pkg::REG_STA: rbus.rdata = {2'h0, switch_on_o};
            default: rbus.rdata = 8'h00;
        endcase
    end
endmodule
`default_nettype wire

// ==== test/lssq_props.sv ====
// checker on the load switch sequencer top ports
// assumes a bind onto lssq_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module lssq_props #(
    parameter int SLOT_CYCLES = 200
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // pins
    input wire logic enable_pin_i,
    input wire logic addr_sel_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    // switch controls
    input wire logic [5:0] switch_on_o,
    input wire logic [5:0] discharge_on_o,
    input wire logic [5:0] rcb_on_o,
    input wire logic seq_active_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    int act_len;
    always_ff @(posedge core_clk_i) begin
        act_len <= seq_active_o ? act_len + 1 : 0;
    end
    sequence s_en_low;
        !enable_pin_i [*6];
    endsequence
    property p_sda_const;
        sda_o == 1'b0;
    endproperty
    a_sda_const: assert property (p_sda_const) else $error("sda data not zero");
    property p_dis_off;
        $stable(switch_on_o) |-> (discharge_on_o & switch_on_o) == 6'h00;
    endproperty
    a_dis_off: assert property (p_dis_off) else $error("discharge on a live channel");
    property p_rcb_off;
        $stable(switch_on_o) |-> (rcb_on_o | switch_on_o) == 6'h3F;
    endproperty
    a_rcb_off: assert property (p_rcb_off) else $error("off channel not blocking");
    property p_en_quiet;
        s_en_low |-> sda_oe_n_o;
    endproperty
    a_en_quiet: assert property (p_en_quiet) else $error("bus driven while disabled");
    property p_en_shut;
        s_en_low |-> switch_on_o == 6'h00 && !seq_active_o;
    endproperty
    a_en_shut: assert property (p_en_shut) else $error("not shut down while disabled");
    property p_en_dflt;
        s_en_low |-> discharge_on_o == 6'h3F && rcb_on_o == 6'h3F;
    endproperty
    a_en_dflt: assert property (p_en_dflt) else $error("shut down outputs not at default");
    property p_scl_low;
        $changed(sda_oe_n_o) |-> !scl_i;
    endproperty
    a_scl_low: assert property (p_scl_low) else $error("sda moved with scl high");
    property p_seq_len;
        $fell(seq_active_o) |-> act_len >= 7 * SLOT_CYCLES - 1 && act_len <= 7 * SLOT_CYCLES + 1;
    endproperty
    a_seq_len: assert property (p_seq_len) else $error("active flag length wrong");
    property p_ack_hold;
        $fell(sda_oe_n_o) |-> !sda_oe_n_o [*8];
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("sda low too short");
endmodule
bind lssq_top lssq_props #(.SLOT_CYCLES(SLOT_CYCLES)) lssq_props_i (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .enable_pin_i(enable_pin_i),
    .addr_sel_i(addr_sel_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .switch_on_o(switch_on_o), .discharge_on_o(discharge_on_o),
    .rcb_on_o(rcb_on_o), .seq_active_o(seq_active_o)
);
`default_nettype wire

// ==== test/lssq_host.sv ====
// i2c controller model of the host processor
// assumes an open drain sda resolved by the bench, scl period 4*Q clocks
`timescale 1ns/1ps
`default_nettype none
module lssq_host #(
    parameter int Q = 25
) (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_n_o
);
    initial begin
        scl_o = 1'b1;
        sda_oe_n_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // data set only while scl low, 100 clocks a bit
    task automatic put_bit(input logic b);
        sda_oe_n_o <= b;
        tick(Q);
        scl_o <= 1'b1;
        tick(2 * Q);
        scl_o <= 1'b0;
        tick(Q);
    endtask
    task automatic get_bit(output logic b);
        sda_oe_n_o <= 1'b1;
        tick(Q);
        scl_o <= 1'b1;
        tick(Q);
        b = sda_i;
        tick(Q);
        scl_o <= 1'b0;
        tick(Q);
    endtask
    task automatic start();
        sda_oe_n_o <= 1'b1;
        tick(Q);
        scl_o <= 1'b1;
        tick(Q);
        sda_oe_n_o <= 1'b0;
        tick(Q);
        scl_o <= 1'b0;
        tick(Q);
    endtask
    task automatic stop();
        sda_oe_n_o <= 1'b0;
        tick(Q);
        scl_o <= 1'b1;
        tick(Q);
        sda_oe_n_o <= 1'b1;
        tick(Q);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack_n);
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(ack_n);
    endtask
    // host acks each read byte but the last
    task automatic rbyte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(last);
    endtask
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the load switch sequencer
// assumes lssq_top, lssq_host and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int SC = 200;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en_pin = 1'b1;
    logic asel = 1'b0;
    logic scl, host_oe_n, dut_sda, dut_oe_n, act;
    logic [5:0] sw, dis, rcb;
    logic [6:0] dev = 7'h18;
    int n_fail = 0;
    int n_checks = 0;
    wire logic sda_w = (dut_oe_n | dut_sda) & host_oe_n;
    lssq_top #(.SLOT_CYCLES(SC)) lssq_top_i (
        .core_clk_i(clk), .rst_n_i(rst_n), .enable_pin_i(en_pin), .addr_sel_i(asel),
        .scl_i(scl), .sda_i(sda_w), .sda_o(dut_sda), .sda_oe_n_o(dut_oe_n),
        .switch_on_o(sw), .discharge_on_o(dis), .rcb_on_o(rcb), .seq_active_o(act)
    );
    lssq_host lssq_host_i (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_oe_n_o(host_oe_n));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wait_for(input logic [5:0] v, input logic a);
        for (int i = 0; i < 3000 && !(sw === v && act === a); i++) wait_clk(1);
    endtask
    // n data bytes from register r onward, d[15:8] first
    task automatic wr(input logic [7:0] r, input logic [15:0] d, input int n, input logic ack);
        logic a;
        logic [7:0] b [4];
        b = '{{dev, 1'b0}, r, d[15:8], d[7:0]};
        lssq_host_i.start();
        for (int i = 0; i < n + 2; i++) begin
            lssq_host_i.wbyte(b[i], a);
            chk("write ack", {7'h00, a}, {7'h00, !ack});
        end
        lssq_host_i.stop();
    endtask
    task automatic rd(input logic [7:0] r, output logic [7:0] d0, output logic [7:0] d1);
        logic a;
        lssq_host_i.start();
        lssq_host_i.wbyte({dev, 1'b0}, a);
        lssq_host_i.wbyte(r, a);
        lssq_host_i.start();
        lssq_host_i.wbyte({dev, 1'b1}, a);
        chk("read ack", {7'h00, a}, 8'h00);
        lssq_host_i.rbyte(1'b0, d0);
        lssq_host_i.rbyte(1'b1, d1);
        lssq_host_i.stop();
    endtask
    task automatic t_reset();
        logic [7:0] x, y;
        chk("switch", {2'b00, sw}, 8'h00);
        chk("discharge", {2'b00, dis}, 8'h3F);
        chk("reverse block", {2'b00, rcb}, 8'h3F);
        rd(8'h02, x, y);
        chk("enable reg", x, 8'h00);
        chk("discharge reg", y, 8'h3F);
    endtask
    task automatic t_direct();
        logic [7:0] x, y;
        wr(8'h02, 16'h0538, 2, 1'b1);
        wr(8'h0A, 16'h0100, 1, 1'b1);
        chk("switch", {2'b00, sw}, 8'h05);
        chk("discharge", {2'b00, dis}, 8'h38);
        chk("reverse block", {2'b00, rcb}, 8'h3B);
        rd(8'h0A, x, y);
        chk("reverse block reg", x, 8'h01);
        chk("status reg", y, 8'h05);
    endtask
    task automatic t_addr();
        asel <= 1'b1;
        wait_clk(4);
        wr(8'h02, 16'h0100, 1, 1'b0);
        chk("switch", {2'b00, sw}, 8'h05);
        dev = 7'h19;
        wr(8'h02, 16'h0200, 1, 1'b1);
        chk("switch", {2'b00, sw}, 8'h02);
        asel <= 1'b0;
        dev = 7'h18;
        wait_clk(4);
    endtask
    task automatic t_seq();
        logic [7:0] x, y;
        wr(8'h69, 16'hB000, 1, 1'b1);
        chk("switch", {2'b00, sw}, 8'h00);
        wr(8'h05, 16'h2107, 2, 1'b1);
        wr(8'h08, 16'h1000, 1, 1'b1);
        chk("active", {7'h00, act}, 8'h01);
        chk("switch", {2'b00, sw}, 8'h01);
        wait_for(6'h07, 1'b0);
        chk("switch", {2'b00, sw}, 8'h07);
        rd(8'h08, x, y);
        chk("sequence reg", x, 8'h00);
        wr(8'h08, 16'h2000, 1, 1'b1);
        chk("switch", {2'b00, sw}, 8'h03);
        wait_for(6'h01, 1'b1);
        chk("active", {7'h00, act}, 8'h01);
        wait_for(6'h00, 1'b0);
        chk("switch", {2'b00, sw}, 8'h00);
    endtask
    task automatic t_enable();
        logic [7:0] x, y;
        wr(8'h02, 16'h3F00, 1, 1'b1);
        chk("switch", {2'b00, sw}, 8'h38);
        en_pin <= 1'b0;
        wait_clk(8);
        chk("switch", {2'b00, sw}, 8'h00);
        chk("discharge", {2'b00, dis}, 8'h3F);
        wr(8'h02, 16'h0100, 1, 1'b0);
        en_pin <= 1'b1;
        wait_clk(8);
        rd(8'h05, x, y);
        chk("slot reg", x, 8'h00);
        chk("slot reg", y, 8'h00);
        chk("switch", {2'b00, sw}, 8'h00);
    endtask
    initial begin
        wait_clk(16);
        rst_n <= 1'b1;
        wait_clk(8);
        t_reset();
        t_direct();
        t_addr();
        t_seq();
        t_enable();
        finish_test();
    end
    initial begin
        wait_clk(90000);
        n_fail++;
        finish_test();
    end
endmodule
`default_nettype wire
